// ===== design/pnp_port.sv
// Parallel programming port, device side
// Functional notes
// - Load clock rising edge loads address, data or command per action select
// - Write or output-enable strobe acts per last loaded command
// - Decode write commands: erase, fuses, lock, flash, EEPROM
// - Decode read commands: signature, fuse and lock, flash, EEPROM
// - Ready/busy low while operation runs, high when ready
// - Drive data bus only while output enable is low
// - Write strobe is active low; its falling edge starts operation
// - Page latch rising edge moves loaded data into page buffer
// - Byte select chooses address, flash data and fuse byte
// - Byte select chooses returned fuse or lock byte when reading
// - Entry pin activity within 100 ns of high voltage refuses mode
// - Command and address stay loaded across operations
// - Chip erase clears flash, EEPROM, lock bits; fuses unchanged
// - Lock bits cleared only after program memory erase completes
// - Keep-EEPROM fuse programmed leaves EEPROM through chip erase
// - Erase command then write strobe gives busy until erase done
// - Flash data latched in page buffer, whole page written
// - Fuses read back programmed as 0, unprogrammed as 1
// - Fuses captured at mode entry; keep-EEPROM fuse acts at once
`timescale 1ns/1ps
`default_nettype none
module pnp_port
    import pnp_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hvPresent,
    input wire pnp_pins_s pins,
    input wire logic [7:0] dataIn,
    input wire logic [15:0] memRdata,
    input wire logic memDone,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic readyBusyN,
    output logic progMode,
    output pnp_memreq_s memReq,
    output logic memStart,
    output pnp_fuse_s fuseActive
);
    // ************************************************************
    // Strobe edges and mode entry
    // ************************************************************
    logic [2:0] rise;
    logic modeActive;
    logic loadRise;
    logic latchRise;
    logic writeFall;

    pnp_edge #(.W(3)) u_edge (
        .clock(clock),
        .reset_n(reset_n),
        .level({pins.loadClockPin, pins.pageLatchPulse, ~pins.writeStrobeN}),
        .rise(rise)
    );

    pnp_entry u_entry (
        .clock(clock),
        .reset_n(reset_n),
        .hvPresent(hvPresent),
        .pattern({pins.pageLatchPulse, pins.strobeActionSel1, pins.strobeActionSel0,
            pins.byteSelLo}),
        .active(modeActive)
    );

    assign loadRise = rise[2];
    assign latchRise = rise[1];
    assign writeFall = rise[0];

    // ************************************************************
    // State
    // ************************************************************
    pnp_state_e state_reg;
    pnp_state_e state_next;
    logic [7:0] cmd_reg;
    logic [7:0] addrLo_reg;
    logic [7:0] addrHi_reg;
    logic [7:0] addrExt_reg;
    logic [7:0] dataLo_reg;
    logic [7:0] dataHi_reg;
    pnp_fuse_s fuse_reg;
    pnp_fuse_s fuse_next;
    logic [7:0] lock_reg;
    logic [7:0] lock_next;
    logic [9:0] timer_reg;
    logic [9:0] timer_next;
    pnp_memreq_s memReq_reg;
    pnp_memreq_s memReq_next;
    logic memStart_reg;
    logic memStart_next;
    pnp_fuse_s fuseActive_reg;
    logic [7:0] dataOut_reg;
    logic dataOe_reg;
    logic readyBusyN_reg;

    // ************************************************************
    // Decoding
    // ************************************************************
    logic [1:0] action;
    logic [1:0] bsel;
    logic idle;
    logic loadAddr;
    logic loadData;
    logic loadCmd;
    logic writeGo;
    logic latchGo;
    logic keepEeprom;
    logic isEraseCmd;
    logic isPageCmd;
    logic isFuseCmd;
    logic isLockCmd;
    logic [7:0] fuseReadByte;
    logic [7:0] memReadByte;
    logic [7:0] readByte;
    pnp_memop_e readOp;
    logic [23:0] fullAddr;

    assign action = {pins.strobeActionSel1, pins.strobeActionSel0};
    assign bsel = {pins.byteSelHi, pins.byteSelLo};
    assign idle = (state_reg == ST_IDLE);
    assign loadAddr = modeActive && idle && loadRise && (action == ACT_ADDR);
    assign loadData = modeActive && idle && loadRise && (action == ACT_DATA);
    assign loadCmd = modeActive && idle && loadRise && (action == ACT_CMD);
    assign writeGo = modeActive && idle && writeFall;
    assign isEraseCmd = (cmd_reg == CMD_CHIP_ERASE);
    assign isFuseCmd = (cmd_reg == CMD_WRITE_FUSE);
    assign isLockCmd = (cmd_reg == CMD_WRITE_LOCK);
    assign isPageCmd = (cmd_reg == CMD_WRITE_FLASH) || (cmd_reg == CMD_WRITE_EEPROM);
    assign latchGo = modeActive && idle && latchRise && isPageCmd;
    assign keepEeprom = !fuse_reg.high[KEEP_EEPROM_BIT];
    assign fullAddr = {addrExt_reg, addrHi_reg, addrLo_reg};

    // Read source per loaded read command
    assign readOp = (cmd_reg == CMD_READ_FLASH) ? MEM_READ_FLASH :
        (cmd_reg == CMD_READ_EEPROM) ? MEM_READ_EEPROM :
        (cmd_reg == CMD_READ_SIG) ? MEM_READ_SIG : MEM_NONE;

    // Stored fuse bits: 0 programmed, 1 unprogrammed
    assign fuseReadByte = (bsel == BSEL_LOW) ? fuse_reg.low :
        (bsel == BSEL_HIGH) ? lock_reg :
        (bsel == BSEL_EXT) ? fuse_reg.ext : fuse_reg.high;

    assign memReadByte = (readOp == MEM_READ_EEPROM || !pins.byteSelLo) ?
        memRdata[7:0] : memRdata[15:8];

    assign readByte = (cmd_reg == CMD_READ_FUSE) ? fuseReadByte :
        (readOp != MEM_NONE) ? memReadByte : 8'h00;

    // ************************************************************
    // Operation sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        fuse_next = fuse_reg;
        lock_next = lock_reg;
        timer_next = timer_reg;
        memStart_next = 1'b0;
        memReq_next = memReq_reg;
        if (idle) begin
            memReq_next = '{op: readOp, addr: fullAddr, data: {dataHi_reg, dataLo_reg}};
        end
        case (state_reg)
            ST_IDLE: begin
                if (latchGo) begin
                    memStart_next = 1'b1;
                    memReq_next.op = (cmd_reg == CMD_WRITE_FLASH) ?
                        MEM_LATCH_FLASH : MEM_LATCH_EEPROM;
                end else if (writeGo && isEraseCmd) begin
                    memStart_next = 1'b1;
                    memReq_next.op = MEM_ERASE_FLASH;
                    state_next = ST_ERASE_FLASH;
                end else if (writeGo && isPageCmd) begin
                    memStart_next = 1'b1;
                    memReq_next.op = (cmd_reg == CMD_WRITE_FLASH) ?
                        MEM_PROG_FLASH : MEM_PROG_EEPROM;
                    state_next = ST_PROGRAM;
                end else if (writeGo && isFuseCmd && bsel != BSEL_RSVD) begin
                    if (bsel == BSEL_LOW) begin
                        fuse_next.low = dataLo_reg;
                    end else if (bsel == BSEL_HIGH) begin
                        fuse_next.high = dataLo_reg;
                    end else begin
                        fuse_next.ext = dataLo_reg;
                    end
                    timer_next = FUSE_WRITE_CYC;
                    state_next = ST_TIMED;
                end else if (writeGo && isLockCmd) begin
                    lock_next = lock_reg & dataLo_reg;
                    timer_next = FUSE_WRITE_CYC;
                    state_next = ST_TIMED;
                end
            end
            ST_ERASE_FLASH: begin
                if (memDone) begin
                    lock_next = LOCK_ERASED;
                    if (keepEeprom) begin
                        state_next = ST_IDLE;
                    end else begin
                        memStart_next = 1'b1;
                        memReq_next.op = MEM_ERASE_EEPROM;
                        state_next = ST_ERASE_EEPROM;
                    end
                end
            end
            ST_ERASE_EEPROM, ST_PROGRAM: begin
                if (memDone) begin
                    state_next = ST_IDLE;
                end
            end
            ST_TIMED: begin
                timer_next = timer_reg - 10'h001;
                if (timer_reg == 10'h001) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            fuse_reg <= FUSE_RST;
            lock_reg <= LOCK_RST;
            timer_reg <= 10'h000;
            memReq_reg <= '{op: MEM_NONE, addr: 24'h000000, data: 16'h0000};
            memStart_reg <= 1'b0;
            readyBusyN_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            fuse_reg <= fuse_next;
            lock_reg <= lock_next;
            timer_reg <= timer_next;
            memReq_reg <= memReq_next;
            memStart_reg <= memStart_next;
            readyBusyN_reg <= (state_next == ST_IDLE);
        end
    end

    // Loaded command, address and data survive operations
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmd_reg <= CMD_NOP;
            addrLo_reg <= 8'h00;
            addrHi_reg <= 8'h00;
            addrExt_reg <= 8'h00;
            dataLo_reg <= 8'h00;
            dataHi_reg <= 8'h00;
        end else begin
            if (loadCmd) begin
                cmd_reg <= dataIn;
            end
            if (loadAddr && bsel == BSEL_LOW) begin
                addrLo_reg <= dataIn;
            end
            if (loadAddr && bsel == BSEL_HIGH) begin
                addrHi_reg <= dataIn;
            end
            if (loadAddr && bsel == BSEL_EXT) begin
                addrExt_reg <= dataIn;
            end
            if (loadData && !pins.byteSelLo) begin
                dataLo_reg <= dataIn;
            end
            if (loadData && pins.byteSelLo) begin
                dataHi_reg <= dataIn;
            end
        end
    end

    // Data bus and fuse image
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dataOut_reg <= 8'h00;
            dataOe_reg <= 1'b0;
            fuseActive_reg <= FUSE_RST;
        end else begin
            dataOut_reg <= readByte;
            dataOe_reg <= modeActive && !pins.outputEnableN;
            if (!modeActive) begin
                fuseActive_reg <= fuse_reg;
            end
        end
    end

    assign dataOut = dataOut_reg;
    assign dataOe = dataOe_reg;
    assign readyBusyN = readyBusyN_reg;
    assign progMode = modeActive;
    assign memReq = memReq_reg;
    assign memStart = memStart_reg;
    assign fuseActive = fuseActive_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_cmd_load_value: assert property (@(posedge clock) disable iff (!reset_n)
        loadCmd |=> cmd_reg == $past(dataIn))
        else $error("Command byte not loaded");

    chk_cmd_retained: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(cmd_reg) |-> $past(loadCmd))
        else $error("Command changed without a load");

    chk_erase_busy: assert property (@(posedge clock) disable iff (!reset_n)
        (writeGo && isEraseCmd) |=> !readyBusyN && memStart && memReq.op == MEM_ERASE_FLASH)
        else $error("Chip erase did not start busy");

    chk_busy_tracks_state: assert property (@(posedge clock) disable iff (!reset_n)
        readyBusyN == (state_reg == ST_IDLE))
        else $error("Ready flag disagrees with sequencer");

    chk_bus_drive_oe: assert property (@(posedge clock) disable iff (!reset_n)
        dataOe == $past(modeActive && !pins.outputEnableN))
        else $error("Data bus drive not following output enable");

    chk_lock_after_flash: assert property (@(posedge clock) disable iff (!reset_n)
        ($changed(lock_reg) && lock_reg == LOCK_ERASED && $past(lock_reg) != LOCK_ERASED)
        |-> $past(state_reg == ST_ERASE_FLASH && memDone))
        else $error("Lock bits cleared before flash erase end");

    chk_erase_fuses_kept: assert property (@(posedge clock) disable iff (!reset_n)
        (state_reg == ST_ERASE_FLASH || state_reg == ST_ERASE_EEPROM) |=> $stable(fuse_reg))
        else $error("Fuses altered by chip erase");

    chk_keep_eeprom: assert property (@(posedge clock) disable iff (!reset_n)
        (state_reg == ST_ERASE_FLASH && memDone && keepEeprom)
        |=> state_reg == ST_IDLE && !memStart ##1 state_reg == ST_IDLE)
        else $error("EEPROM erased despite keep fuse");

    chk_fuse_frozen: assert property (@(posedge clock) disable iff (!reset_n)
        (modeActive && $past(modeActive)) |=> $stable(fuseActive))
        else $error("Active fuses changed in programming mode");

    chk_page_latch: assert property (@(posedge clock) disable iff (!reset_n)
        latchGo |=> memStart && (memReq.op == MEM_LATCH_FLASH
        || memReq.op == MEM_LATCH_EEPROM) && readyBusyN)
        else $error("Page latch not forwarded");

    chk_fuse_read: assert property (@(posedge clock) disable iff (!reset_n)
        (cmd_reg == CMD_READ_FUSE && bsel == BSEL_HIGH) |=> dataOut == $past(lock_reg))
        else $error("Lock byte not returned");
endmodule
`default_nettype wire

// ===== design/pnp_pkg.sv
// Shared constants and types for the parallel programming port
package pnp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned ENTRY_HOLD_NS = 100;
    localparam logic [4:0] ENTRY_HOLD_CYC =
        5'((ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned FUSE_WRITE_NS = 5000;
    localparam logic [9:0] FUSE_WRITE_CYC =
        10'((FUSE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************************
    // Pin codes
    // ************************************************************
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    localparam logic [1:0] BSEL_LOW = 2'h0;
    localparam logic [1:0] BSEL_HIGH = 2'h1;
    localparam logic [1:0] BSEL_EXT = 2'h2;
    localparam logic [1:0] BSEL_RSVD = 2'h3;
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;

    // ************************************************************
    // Command bytes
    // ************************************************************
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_READ_SIG = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE = 8'h04;
    localparam logic [7:0] CMD_READ_FLASH = 8'h02;
    localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

    // ************************************************************
    // Fuse and lock values
    // ************************************************************
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [7:0] LOCK_ERASED = 8'hff;
    localparam int unsigned KEEP_EEPROM_BIT = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        MEM_NONE = 4'h0,
        MEM_ERASE_FLASH = 4'h1,
        MEM_ERASE_EEPROM = 4'h2,
        MEM_LATCH_FLASH = 4'h3,
        MEM_LATCH_EEPROM = 4'h4,
        MEM_PROG_FLASH = 4'h5,
        MEM_PROG_EEPROM = 4'h6,
        MEM_READ_FLASH = 4'h7,
        MEM_READ_EEPROM = 4'h8,
        MEM_READ_SIG = 4'h9
    } pnp_memop_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ERASE_FLASH = 5'h02,
        ST_ERASE_EEPROM = 5'h04,
        ST_PROGRAM = 5'h08,
        ST_TIMED = 5'h10
    } pnp_state_e;

    typedef struct packed {
        logic pageLatchPulse;
        logic strobeActionSel1;
        logic strobeActionSel0;
        logic byteSelHi;
        logic byteSelLo;
        logic writeStrobeN;
        logic outputEnableN;
        logic loadClockPin;
    } pnp_pins_s;

    typedef struct packed {
        pnp_memop_e op;
        logic [23:0] addr;
        logic [15:0] data;
    } pnp_memreq_s;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } pnp_fuse_s;

    localparam pnp_fuse_s FUSE_RST = '{ext: FUSE_EXT_RST, high: FUSE_HIGH_RST,
        low: FUSE_LOW_RST};

endpackage

// ===== design/pnp_edge.sv
// Rising edge detector for synchronous pin strobes
`timescale 1ns/1ps
`default_nettype none
module pnp_edge #(
    parameter int W = 3
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] prev_reg;

    assign rise = level & ~prev_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end
endmodule
`default_nettype wire

// ===== design/pnp_entry.sv
// Programming mode entry qualifier
`timescale 1ns/1ps
`default_nettype none
module pnp_entry
    import pnp_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hvPresent,
    input wire logic [3:0] pattern,
    output logic active
);
    logic [4:0] holdCnt_reg;
    logic failed_reg;
    logic active_reg;
    logic patternOk;

    assign patternOk = (pattern == ENTRY_PATTERN);
    assign active = active_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt_reg <= 5'h00;
            failed_reg <= 1'b0;
            active_reg <= 1'b0;
        end else if (!hvPresent) begin
            holdCnt_reg <= 5'h00;
            failed_reg <= 1'b0;
            active_reg <= 1'b0;
        end else if (!active_reg && !failed_reg) begin
            if (!patternOk) begin
                failed_reg <= 1'b1;
            end else if (holdCnt_reg == ENTRY_HOLD_CYC - 5'h01) begin
                active_reg <= 1'b1;
            end else begin
                holdCnt_reg <= holdCnt_reg + 5'h01;
            end
        end
    end

    chk_entry_refused: assert property (@(posedge clock) disable iff (!reset_n)
        (hvPresent && !active_reg && !patternOk) |=> !active_reg [*3])
        else $error("Entry accepted despite pattern activity");
endmodule
`default_nettype wire

// ===== testbench/pnp_mem_model.sv
// Memory side model for the programming port
`timescale 1ns/1ps
`default_nettype none
module pnp_mem_model
    import pnp_pkg::*;
#(
    parameter int DLY = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire pnp_memreq_s memReq,
    input wire logic memStart,
    output logic [15:0] memRdata,
    output logic memDone
);
    // ****************
    // Memory response
    // ****************
    int cnt[16];
    int left;
    // Read word follows the low address byte, so locations differ only within a 256-word block
    assign memRdata = {~memReq.addr[7:0], memReq.addr[7:0]};
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            left <= 0;
            memDone <= 1'b0;
        end else begin
            memDone <= (left == 1);
            if (left > 0) left <= left - 1;
            if (memStart) begin
                cnt[memReq.op] <= cnt[memReq.op] + 1;
                if (memReq.op inside {MEM_ERASE_FLASH, MEM_ERASE_EEPROM,
                    MEM_PROG_FLASH, MEM_PROG_EEPROM}) left <= DLY;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/pnp_port_tb.sv
// Self-checking testbench for the programming port
`timescale 1ns/1ps
`default_nettype none
module pnp_port_tb
    import pnp_pkg::*;
;
    logic clock, reset_n, hvPresent, memDone, dataOe, readyBusyN, progMode, memStart;
    pnp_pins_s p;
    logic [7:0] dataIn, dataOut;
    logic [15:0] memRdata;
    pnp_memreq_s memReq;
    pnp_fuse_s fuseActive;
    logic [7:0] fr[4];
    int n_mismatch, n_compared, i;
    pnp_port pnp_port_i (.clock(clock), .reset_n(reset_n), .hvPresent(hvPresent),
        .pins(p), .dataIn(dataIn), .memRdata(memRdata), .memDone(memDone),
        .dataOut(dataOut), .dataOe(dataOe), .readyBusyN(readyBusyN),
        .progMode(progMode), .memReq(memReq), .memStart(memStart),
        .fuseActive(fuseActive));
    pnp_mem_model pnp_mem_model_i (.clock(clock), .reset_n(reset_n),
        .memReq(memReq), .memStart(memStart), .memRdata(memRdata), .memDone(memDone));
    // ****************
    // Access tasks
    // ****************
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] b);
        {p.strobeActionSel1, p.strobeActionSel0} = act;
        {p.byteSelHi, p.byteSelLo} = bs;
        dataIn = b;
        tick();
        p.loadClockPin = 1'b1;
        tick();
        p.loadClockPin = 1'b0;
        tick();
    endtask
    task automatic strobe(input logic [1:0] bs);
        {p.byteSelHi, p.byteSelLo} = bs;
        tick();
        p.writeStrobeN = 1'b0;
        tick();
        p.writeStrobeN = 1'b1;
        tick();
        chk(readyBusyN, 1'b0);
        for (i = 0; i < 3000 && readyBusyN !== 1'b1; i++) tick();
        chk(readyBusyN, 1'b1);
    endtask
    task automatic op(input logic [7:0] cmd, input logic [7:0] d, input logic [1:0] bs);
        load(ACT_CMD, BSEL_LOW, cmd);
        load(ACT_DATA, BSEL_LOW, d);
        strobe(bs);
    endtask
    task automatic rd(input logic [1:0] bs, input logic [7:0] exp);
        {p.byteSelHi, p.byteSelLo} = bs;
        p.outputEnableN = 1'b0;
        tick(2);
        chk(dataOe, 1'b1);
        chk(dataOut, exp);
        p.outputEnableN = 1'b1;
        tick(2);
        chk(dataOe, 1'b0);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #(20000 * 5);
        n_mismatch++;
        results();
    end
    initial begin
        fr = '{FUSE_LOW_RST, LOCK_RST, FUSE_EXT_RST, FUSE_HIGH_RST};
        reset_n = 1'b0;
        hvPresent = 1'b0;
        p = '0;
        p.writeStrobeN = 1'b1;
        p.outputEnableN = 1'b1;
        dataIn = 8'h00;
        n_mismatch = 0;
        n_compared = 0;
        tick(2);
        reset_n = 1'b1;
        chk(readyBusyN, 1'b1);
        chk(progMode, 1'b0);
        chk(fuseActive, FUSE_RST);
        tick(20);
        hvPresent = 1'b1;
        tick(5);
        p.pageLatchPulse = 1'b1;
        tick();
        p.pageLatchPulse = 1'b0;
        tick(30);
        chk(progMode, 1'b0);
        hvPresent = 1'b0;
        tick(2);
        repeat (6) begin
            p.loadClockPin = 1'b1;
            tick();
            p.loadClockPin = 1'b0;
            tick();
        end
        hvPresent = 1'b1;
        tick(18);
        chk(progMode, 1'b0);
        tick(4);
        chk(progMode, 1'b1);
        tick(10000);
        load(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
        for (int k = 0; k < 4; k++) rd(2'(k), fr[k]);
        op(CMD_WRITE_LOCK, 8'h00, BSEL_LOW);
        op(CMD_WRITE_FUSE, 8'h5a, BSEL_LOW);
        chk(fuseActive, FUSE_RST);
        load(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
        rd(BSEL_HIGH, 8'h00);
        rd(BSEL_LOW, 8'h5a);
        op(CMD_CHIP_ERASE, 8'h00, BSEL_LOW);
        chk(pnp_mem_model_i.cnt[MEM_ERASE_FLASH], 1);
        chk(pnp_mem_model_i.cnt[MEM_ERASE_EEPROM], 1);
        load(ACT_CMD, BSEL_LOW, CMD_READ_FUSE);
        rd(BSEL_HIGH, LOCK_ERASED);
        rd(BSEL_LOW, 8'h5a);
        op(CMD_WRITE_FUSE, 8'h91, BSEL_HIGH);
        op(CMD_CHIP_ERASE, 8'h00, BSEL_LOW);
        chk(pnp_mem_model_i.cnt[MEM_ERASE_EEPROM], 1);
        load(ACT_CMD, BSEL_LOW, CMD_WRITE_FLASH);
        load(ACT_ADDR, BSEL_LOW, 8'h34);
        load(ACT_DATA, BSEL_LOW, 8'hcd);
        load(ACT_DATA, BSEL_HIGH, 8'hab);
        p.pageLatchPulse = 1'b1;
        tick();
        p.pageLatchPulse = 1'b0;
        tick(2);
        chk(memReq.data, 16'habcd);
        chk(pnp_mem_model_i.cnt[MEM_LATCH_FLASH], 1);
        strobe(BSEL_LOW);
        chk(pnp_mem_model_i.cnt[MEM_PROG_FLASH], 1);
        load(ACT_CMD, BSEL_LOW, CMD_READ_FLASH);
        rd(BSEL_LOW, 8'h34);
        rd(BSEL_HIGH, 8'hcb);
        load(ACT_ADDR, BSEL_EXT, 8'h02);
        load(ACT_ADDR, BSEL_RSVD, 8'h55);
        chk(memReq.addr, 24'h020034);
        load(ACT_IDLE, BSEL_LOW, 8'h77);
        rd(BSEL_LOW, 8'h34);
        load(ACT_CMD, BSEL_LOW, CMD_READ_EEPROM);
        rd(BSEL_LOW, 8'h34);
        load(ACT_CMD, BSEL_LOW, CMD_READ_SIG);
        rd(BSEL_HIGH, 8'hcb);
        hvPresent = 1'b0;
        tick(2);
        chk(progMode, 1'b0);
        chk(fuseActive, 24'hff915a);
        p.outputEnableN = 1'b0;
        tick(2);
        chk(dataOe, 1'b0);
        results();
    end
endmodule
`default_nettype wire
